// *** dv/stt_pin_model.sv ***
`timescale 1ns/1ps
module stt_pin_model (
	input  wire logic aclk,    // System clock
	output logic      clk_pin, // External clock pin
	output logic      cap_pin  // Capture pin
);
	initial
	begin
		clk_pin = 1'b0;
		cap_pin = 1'b0;
	end

	task automatic pulses(input logic cap, input int n, input int hold);
		repeat (n)
		begin
			@(posedge aclk);
			if (cap) cap_pin <= 1'b1;
			else clk_pin <= 1'b1;
			repeat (hold) @(posedge aclk);
			cap_pin <= 1'b0;
			clk_pin <= 1'b0;
			repeat (hold) @(posedge aclk);
		end
	endtask : pulses
endmodule : stt_pin_model

// *** dv/stt_timer_assertions.sv ***
`timescale 1ns/1ps
module stt_timer_assertions (
	input wire logic        aclk,          // System clock
	input wire logic        aresetn,       // Sync reset, low
	input wire logic        s_axi_awvalid, // Write address valid
	input wire logic        s_axi_awready, // Write address ready
	input wire logic        s_axi_wvalid,  // Write data valid
	input wire logic        s_axi_wready,  // Write data ready
	input wire logic        s_axi_bvalid,  // Write response valid
	input wire logic        s_axi_bready,  // Write response ready
	input wire logic [7:0]  s_axi_araddr,  // Read address
	input wire logic        s_axi_arvalid, // Read address valid
	input wire logic        s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata,   // Read data
	input wire logic [1:0]  s_axi_rresp,   // Read response
	input wire logic        s_axi_rvalid,  // Read data valid
	input wire logic        s_axi_rready,  // Read data ready
	input wire logic        match_a_req,   // Comparator A request
	input wire logic        match_p_req    // Comparator P request
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========
	// Register bus
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read not answered");
	a_read_once: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid) else $error("read answered twice");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_write_once: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("write answered twice");
	a_read_quiet: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_write_quiet: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_byte_wide: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits");
	a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > 8'h18
		|=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
		else $error("unmapped read accepted");

	// ==========
	// Timer
	a_p_sparse: assert property (match_p_req
		|=> (!match_p_req)[*8]) else $error("period match too soon");

	c_match_a: cover property (match_a_req);
	c_match_p: cover property (match_p_req);
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule : stt_timer_assertions

bind stt_timer stt_timer_assertions u_stt_timer_assertions (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .match_a_req, .match_p_req
);

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`include "stt_defs.svh"
module testbench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, high_clk_tick, sub_clk_tick;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, timer_out_pin, match_a_req, match_p_req;
	logic        timer_clock_pin, timer_capture_pin, o_last, toggled;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	int          mismatches = 0, samples_checked = 0, cyc = 0;
	int          last_a, last_p, gap_a, gap_p, n_a;
	int          exp_cap[4] = '{2, 2, 4, 0};
	int          dv[4] = '{4, 32, 128, 8};
	logic [7:0]  ck[4] = '{8'h08, 8'h28, 8'h38, 8'h48};
	int          hi;

	stt_timer u_stt_timer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_clk_tick,
		.sub_clk_tick, .timer_clock_pin, .timer_capture_pin,
		.timer_out_pin, .match_a_req, .match_p_req);
	stt_pin_model u_stt_pin_model (.aclk, .clk_pin(timer_clock_pin),
		.cap_pin(timer_capture_pin));

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		high_clk_tick <= ~high_clk_tick;
		sub_clk_tick  <= (cyc % 8 == 0);
	end

	// ==========
	// Request monitor
	always @(negedge aclk)
	begin
		cyc++;
		if (match_a_req === 1'b1)
		begin
			n_a++;
			gap_a = cyc - last_a;
			last_a = cyc;
			toggled = (timer_out_pin !== o_last);
			o_last = timer_out_pin;
		end
		if (match_p_req === 1'b1)
		begin
			gap_p = cyc - last_p;
			last_p = cyc;
		end
	end

	// ==========
	// Bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, b;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			b  = s_axi_bvalid;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		while (!b);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic t, v;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(negedge aclk);
			t  = s_axi_arvalid & s_axi_arready;
			v  = s_axi_rvalid;
			rd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge aclk);
			if (t) s_axi_arvalid <= 1'b0;
		end
		while (!v);
		chk(rd, e);
	endtask : rdc

	task automatic rcnt(input logic [9:0] e);
		rdc(`STT_OFF_CNT_HI, {30'h0, e[9:8]});
		rdc(`STT_OFF_CNT_LO, {24'h0, e[7:0]});
	endtask : rcnt

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	initial
	begin
		repeat (30000) @(posedge aclk);
		mismatches++;
		summarize();
	end

	// ==========
	// Tests
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{high_clk_tick, sub_clk_tick} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdc(`STT_OFF_CTRL, 32'h0000_0000);
		rdc(`STT_OFF_MODE, 32'h0000_0000);
		wr(`STT_OFF_CTRL, 8'hA5);
		rdc(`STT_OFF_CTRL, 32'h0000_00A5);
		rdc(8'h1C, 32'h0000_0000);
		chk({30'h0, rr}, 32'h0000_0002);
		wr(`STT_OFF_CTRL, 8'h00);
		$display("registers done");
		wr(`STT_OFF_MA_LO, 8'h55);
		rdc(`STT_OFF_MA_HI, 32'h0000_0000);
		rdc(`STT_OFF_MA_LO, 32'h0000_0000);
		wr(`STT_OFF_MA_LO, 8'h55);
		wr(`STT_OFF_MA_HI, 8'h03);
		rdc(`STT_OFF_MA_HI, 32'h0000_0003);
		rdc(`STT_OFF_MA_LO, 32'h0000_0055);
		$display("buffer done");
		wr(`STT_OFF_CTRL, 8'h68);
		u_stt_pin_model.pulses(1'b0, 5, 6);
		rcnt(10'd5);
		wr(`STT_OFF_CTRL, 8'h70);
		u_stt_pin_model.pulses(1'b0, 2, 6);
		rcnt(10'd5);
		wr(`STT_OFF_CTRL, 8'h78);
		u_stt_pin_model.pulses(1'b0, 3, 6);
		rcnt(10'd3);
		wr(`STT_OFF_CTRL, 8'hF8);
		u_stt_pin_model.pulses(1'b0, 2, 6);
		rcnt(10'd3);
		wr(`STT_OFF_CTRL, 8'h78);
		u_stt_pin_model.pulses(1'b0, 1, 6);
		rcnt(10'd4);
		$display("counter done");
		wr(`STT_OFF_CTRL, 8'h00);
		wr(`STT_OFF_MODE, 8'h39);
		wr(`STT_OFF_MA_LO, 8'h05);
		wr(`STT_OFF_MA_HI, 8'h00);
		wr(`STT_OFF_CTRL, 8'h18);
		@(negedge aclk);
		chk({31'h0, timer_out_pin}, 32'h1);
		repeat (20) @(posedge aclk);
		chk(gap_a, 32'd5);
		chk({31'h0, toggled}, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			wr(`STT_OFF_CTRL, 8'h00);
			wr(`STT_OFF_CTRL, ck[i]);
			repeat (15 * dv[i] + 20) @(posedge aclk);
			chk(gap_a, 5 * dv[i]);
		end
		wr(`STT_OFF_CTRL, 8'h00);
		rdc(`STT_OFF_STATUS, 32'h0000_0001);
		wr(`STT_OFF_STATUS, 8'h01);
		rdc(`STT_OFF_STATUS, 32'h0000_0000);
		$display("compare done");
		wr(`STT_OFF_CTRL, 8'h00);
		wr(`STT_OFF_MODE, 8'h30);
		for (int c = 1; c < 8; c++)
		begin
			wr(`STT_OFF_CTRL, 8'h00);
			wr(`STT_OFF_CTRL, 8'h18 | c[7:0]);
			repeat (256 * c + 10) @(posedge aclk);
			chk(gap_p, 128 * c);
		end
		wr(`STT_OFF_CTRL, 8'h00);
		wr(`STT_OFF_CTRL, 8'h18);
		repeat (2100) @(posedge aclk);
		chk(gap_a, 1024);
		wr(`STT_OFF_CTRL, 8'h00);
		rdc(`STT_OFF_STATUS, 32'h0000_0003);
		$display("period done");
		wr(`STT_OFF_MODE, 8'hA8);
		wr(`STT_OFF_CTRL, 8'h19);
		hi = 0;
		repeat (128)
		begin
			@(negedge aclk);
			if (timer_out_pin === 1'b1) hi++;
		end
		chk(hi, 5);
		wr(`STT_OFF_CTRL, 8'h00);
		wr(`STT_OFF_MODE, 8'hB8);
		wr(`STT_OFF_CTRL, 8'h18);
		n_a = 0;
		@(negedge aclk);
		chk({31'h0, timer_out_pin}, 32'h1);
		u_stt_pin_model.pulses(1'b0, 1, 6);
		repeat (20) @(posedge aclk);
		chk(n_a, 1);
		chk({31'h0, timer_out_pin}, 32'h0);
		$display("pwm done");
		wr(`STT_OFF_CTRL, 8'h00);
		for (int f = 0; f < 4; f++)
		begin
			wr(`STT_OFF_MODE, 8'h40 | (f[7:0] << 4));
			wr(`STT_OFF_CTRL, 8'h68);
			n_a = 0;
			u_stt_pin_model.pulses(1'b1, 2, 6);
			chk(n_a, exp_cap[f]);
			wr(`STT_OFF_CTRL, 8'h00);
		end
		$display("capture done");
		summarize();
	end
endmodule : testbench

// *** logic/stt_defs.svh ***
`ifndef STT_DEFS_SVH
`define STT_DEFS_SVH

// ==========================================================
// Register byte offsets
`define STT_OFF_CTRL     8'h00
`define STT_OFF_MODE     8'h04
`define STT_OFF_CNT_LO   8'h08
`define STT_OFF_CNT_HI   8'h0C
`define STT_OFF_MA_LO    8'h10
`define STT_OFF_MA_HI    8'h14
`define STT_OFF_STATUS   8'h18

// ==========================================================
// Reset values
`define STT_CTRL_RST     8'h00
`define STT_MODE_RST     8'h00

// ==========================================================
// counter_control fields
`define STT_PAUSE_BIT    7
`define STT_CKSEL_HI     6
`define STT_CKSEL_LO     4
`define STT_ON_BIT       3
`define STT_PERIOD_HI    2
`define STT_PERIOD_LO    0

// ==========================================================
// mode_control fields
`define STT_OPMODE_HI    7
`define STT_OPMODE_LO    6
`define STT_PINFN_HI     5
`define STT_PINFN_LO     4
`define STT_OC_BIT       3
`define STT_POL_BIT      2
`define STT_DPX_BIT      1
`define STT_CCLR_BIT     0

// ==========================================================
// status fields
`define STT_STAT_A_BIT   0
`define STT_STAT_P_BIT   1

// ==========================================================
// Prescaler terminal counts
`define STT_SYS_DIV4_MAX 2'h3
`define STT_HI_DIV16_MAX 4'hF
`define STT_HI_DIV64_MAX 6'h3F

`endif

// *** logic/stt_pkg.sv ***
package stt_pkg;

	// ==========================================================
	// Operating modes
	typedef enum logic [1:0] {
		STT_MODE_CMP  = 2'h0,
		STT_MODE_CAP  = 2'h1,
		STT_MODE_PWM  = 2'h2,
		STT_MODE_TMR  = 2'h3
	} stt_mode_type;

	// Single pulse sequencer, one-hot
	typedef enum logic [1:0] {
		STT_SP_IDLE   = 2'b01,
		STT_SP_ACTIVE = 2'b10
	} stt_sp_type;

	// ==========================================================
	// Whole state of the timer block
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  mode;
		logic [9:0]  cnt;
		logic [9:0]  match_a;
		logic [7:0]  hold_buf;
		logic        lvl;
		logic        pin_out;
		stt_sp_type  sp;
		logic        flag_a;
		logic        flag_p;
		logic        req_a;
		logic        req_p;
		logic [1:0]  div4;
		logic [5:0]  hdiv;
		logic [2:0]  ext_sync;
		logic        ext_st;
		logic [2:0]  cap_sync;
		logic        cap_st;
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [7:0]  w_data;
		logic        w_lane0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [7:0]  rdata;
		logic [1:0]  rresp;
	} stt_state_type;

endpackage : stt_pkg

// *** logic/stt_timer.sv ***
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "stt_defs.svh"

module stt_timer (
	input  wire logic        aclk,             // System clock
	input  wire logic        aresetn,          // Sync reset, low
	input  wire logic [7:0]  s_axi_awaddr,     // Write address
	input  wire logic        s_axi_awvalid,    // Write address valid
	output logic             s_axi_awready,    // Write address ready
	input  wire logic [31:0] s_axi_wdata,      // Write data
	input  wire logic [3:0]  s_axi_wstrb,      // Write strobes
	input  wire logic        s_axi_wvalid,     // Write data valid
	output logic             s_axi_wready,     // Write data ready
	output logic [1:0]       s_axi_bresp,      // Write response
	output logic             s_axi_bvalid,     // Write response valid
	input  wire logic        s_axi_bready,     // Write response ready
	input  wire logic [7:0]  s_axi_araddr,     // Read address
	input  wire logic        s_axi_arvalid,    // Read address valid
	output logic             s_axi_arready,    // Read address ready
	output logic [31:0]      s_axi_rdata,      // Read data
	output logic [1:0]       s_axi_rresp,      // Read response
	output logic             s_axi_rvalid,     // Read data valid
	input  wire logic        s_axi_rready,     // Read data ready
	input  wire logic        high_clk_tick,    // High clock enable pulse
	input  wire logic        sub_clk_tick,     // Sub clock enable pulse
	input  wire logic        timer_clock_pin,  // External clock pin
	input  wire logic        timer_capture_pin,// Capture pin
	output logic             timer_out_pin,    // Timer output pin
	output logic             match_a_req,      // Comparator A request
	output logic             match_p_req       // Comparator P request
);

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	stt_pkg::stt_state_type s_reg;
	stt_pkg::stt_state_type s_next;

	logic [2:0]  clock_select;
	logic        counter_on;
	logic        pause_control;
	logic [2:0]  period_compare_value;
	stt_pkg::stt_mode_type operating_mode_field;
	logic [1:0]  pin_function_field;
	logic        output_initial_level;
	logic        out_invert;
	logic        pwm_swap;
	logic        clear_source_select;
	logic        ext_rise;
	logic        ext_fall;
	logic        cap_rise;
	logic        cap_fall;
	logic        cnt_tick;
	logic        sp_mode;
	logic        run;
	logic [10:0] inc;
	logic        a_hit;
	logic        p_hit;
	logic        ovf;
	logic        clr_cnt;
	logic        set_a;
	logic        set_p;
	logic        clr_a;
	logic        clr_p;
	logic        cap_edge;
	logic [9:0]  duty;
	logic        wr_go;
	logic        on_rise;
	logic [7:0]  ctrl_new;

	always_comb
	begin
		clock_select         = s_reg.ctrl[`STT_CKSEL_HI:`STT_CKSEL_LO];
		counter_on           = s_reg.ctrl[`STT_ON_BIT];
		pause_control        = s_reg.ctrl[`STT_PAUSE_BIT];
		period_compare_value = s_reg.ctrl[`STT_PERIOD_HI:`STT_PERIOD_LO];
		operating_mode_field = stt_pkg::stt_mode_type'(
			s_reg.mode[`STT_OPMODE_HI:`STT_OPMODE_LO]);
		pin_function_field   = s_reg.mode[`STT_PINFN_HI:`STT_PINFN_LO];
		output_initial_level = s_reg.mode[`STT_OC_BIT];
		out_invert           = s_reg.mode[`STT_POL_BIT];
		pwm_swap             = s_reg.mode[`STT_DPX_BIT];
		clear_source_select  = s_reg.mode[`STT_CCLR_BIT];
	end

	// ==========================================================
	// Pin filtering and edges
	// sync before use
	always_comb
	begin
		ext_rise = (s_reg.ext_sync[2] == s_reg.ext_sync[1])
			&& s_reg.ext_sync[2] && !s_reg.ext_st;
		ext_fall = (s_reg.ext_sync[2] == s_reg.ext_sync[1])
			&& !s_reg.ext_sync[2] && s_reg.ext_st;
		cap_rise = (s_reg.cap_sync[2] == s_reg.cap_sync[1])
			&& s_reg.cap_sync[2] && !s_reg.cap_st;
		cap_fall = (s_reg.cap_sync[2] == s_reg.cap_sync[1])
			&& !s_reg.cap_sync[2] && s_reg.cap_st;
	end

	// ==========================================================
	// Counter clock selection
	// clock source mux
	always_comb
	begin
		case (clock_select)
			3'h0:    cnt_tick = (s_reg.div4 == `STT_SYS_DIV4_MAX);
			3'h1:    cnt_tick = 1'b1;
			3'h2:    cnt_tick = high_clk_tick
				&& (s_reg.hdiv[3:0] == `STT_HI_DIV16_MAX);
			3'h3:    cnt_tick = high_clk_tick
				&& (s_reg.hdiv == `STT_HI_DIV64_MAX);
			3'h6:    cnt_tick = ext_rise;
			3'h7:    cnt_tick = ext_fall;
			default: cnt_tick = sub_clk_tick;
		endcase
	end

	// ==========================================================
	// Compare logic on the next counter value
	always_comb
	begin
		sp_mode = (operating_mode_field == stt_pkg::STT_MODE_PWM)
			&& (pin_function_field == 2'h3);
		run = counter_on && !pause_control && cnt_tick
			&& (!sp_mode || s_reg.sp == stt_pkg::STT_SP_ACTIVE);
		inc = {1'b0, s_reg.cnt} + 11'h001;
		ovf = inc[10];
		a_hit = (inc[9:0] == s_reg.match_a) && !ovf;
		p_hit = (period_compare_value != 3'h0)
			&& (inc[9:7] == period_compare_value)
			&& (inc[6:0] == 7'h00);
		duty = pwm_swap ? {period_compare_value, 7'h00} : s_reg.match_a;
		case (operating_mode_field)
			stt_pkg::STT_MODE_PWM:
				clr_cnt = pwm_swap ? a_hit : (p_hit || ovf);
			stt_pkg::STT_MODE_CAP:
				clr_cnt = p_hit || ovf;
			default:
				clr_cnt = clear_source_select ? a_hit : (p_hit || ovf);
		endcase
		set_a = run && a_hit && (s_reg.match_a != 10'h000);
		set_p = run && p_hit && !(clear_source_select
			&& operating_mode_field == stt_pkg::STT_MODE_CMP);
		case (pin_function_field)
			2'h0:    cap_edge = cap_rise;
			2'h1:    cap_edge = cap_fall;
			2'h2:    cap_edge = cap_rise || cap_fall;
			default: cap_edge = 1'b0;
		endcase
		wr_go = s_reg.aw_got && s_reg.w_got && s_reg.w_lane0;
		ctrl_new = s_reg.w_data;
		on_rise = wr_go && (s_reg.aw_addr == `STT_OFF_CTRL)
			&& !counter_on && ctrl_new[`STT_ON_BIT];
		clr_a = wr_go && (s_reg.aw_addr == `STT_OFF_STATUS)
			&& s_reg.w_data[`STT_STAT_A_BIT];
		clr_p = wr_go && (s_reg.aw_addr == `STT_OFF_STATUS)
			&& s_reg.w_data[`STT_STAT_P_BIT];
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		s_next = s_reg;
		s_next.req_a = 1'b0;
		s_next.req_p = 1'b0;
		// First stage feeds only the second
		s_next.ext_sync = {s_reg.ext_sync[1:0], timer_clock_pin};
		s_next.cap_sync = {s_reg.cap_sync[1:0], timer_capture_pin};
		if (s_reg.ext_sync[2] == s_reg.ext_sync[1])
			s_next.ext_st = s_reg.ext_sync[2];
		if (s_reg.cap_sync[2] == s_reg.cap_sync[1])
			s_next.cap_st = s_reg.cap_sync[2];
		s_next.div4 = s_reg.div4 + 2'h1;
		if (high_clk_tick)
			s_next.hdiv = s_reg.hdiv + 6'h01;

		if (run)
			s_next.cnt = clr_cnt ? 10'h000 : inc[9:0];
		s_next.req_a = set_a;
		s_next.req_p = set_p;

		case (operating_mode_field)
			stt_pkg::STT_MODE_CMP:
			begin
				if (set_a)
				begin
					case (pin_function_field)
						2'h1:    s_next.lvl = 1'b0;
						2'h2:    s_next.lvl = 1'b1;
						2'h3:    s_next.lvl = !s_reg.lvl;
						default: s_next.lvl = s_reg.lvl;
					endcase
				end
			end
			stt_pkg::STT_MODE_CAP:
			begin
				if (counter_on && cap_edge)
				begin
					s_next.match_a = s_reg.cnt;
					s_next.req_a = 1'b1;
				end
			end
			stt_pkg::STT_MODE_PWM:
			begin
				case (pin_function_field)
					2'h0:    s_next.lvl = !output_initial_level;
					2'h1:    s_next.lvl = output_initial_level;
					2'h2:    s_next.lvl = (s_next.cnt < duty)
						? output_initial_level : !output_initial_level;
					default:
					begin
						if (s_reg.sp == stt_pkg::STT_SP_IDLE)
						begin
							if (counter_on && ext_rise)
							begin
								s_next.sp  = stt_pkg::STT_SP_ACTIVE;
								s_next.cnt = 10'h000;
								s_next.lvl = output_initial_level;
							end
						end
						else if (set_a || !counter_on)
						begin
							s_next.sp  = stt_pkg::STT_SP_IDLE;
							s_next.lvl = !output_initial_level;
						end
					end
				endcase
			end
			default:
				s_next.lvl = s_reg.lvl;
		endcase

		// ======================================================
		// Register writes
		s_next.bvalid  = s_reg.bvalid && !s_axi_bready;
		if (s_axi_awvalid && s_reg.awready)
		begin
			s_next.aw_got  = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready)
		begin
			s_next.w_got   = 1'b1;
			s_next.w_data  = s_axi_wdata[7:0];
			s_next.w_lane0 = s_axi_wstrb[0];
		end
		if (s_reg.aw_got && s_reg.w_got)
		begin
			s_next.aw_got = 1'b0;
			s_next.w_got  = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp  = RESP_OKAY;
			if (s_reg.aw_addr[1:0] != 2'h0
				|| s_reg.aw_addr > `STT_OFF_STATUS)
				s_next.bresp = RESP_SLVERR;
		end
		if (wr_go)
		begin
			if (s_reg.aw_addr == `STT_OFF_CTRL)
			begin
				s_next.ctrl = ctrl_new;
				if (on_rise)
				begin
					s_next.cnt = 10'h000;
					s_next.sp  = stt_pkg::STT_SP_IDLE;
				end
				if (on_rise && operating_mode_field
					!= stt_pkg::STT_MODE_CAP)
					s_next.lvl = output_initial_level;
			end
			else if (s_reg.aw_addr == `STT_OFF_MODE)
				s_next.mode = s_reg.w_data;
			else if (s_reg.aw_addr == `STT_OFF_MA_LO)
				s_next.hold_buf = s_reg.w_data;
			else if (s_reg.aw_addr == `STT_OFF_MA_HI)
				s_next.match_a = {s_reg.w_data[1:0], s_reg.hold_buf};
		end
		// Set wins over a same-cycle clear
		s_next.flag_a = (s_reg.flag_a && !clr_a) || s_next.req_a;
		s_next.flag_p = (s_reg.flag_p && !clr_p) || set_p;

		// ======================================================
		// Register reads
		if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'b0;
		if (s_axi_arvalid && s_reg.arready)
		begin
			s_next.rvalid = 1'b1;
			s_next.rresp  = RESP_OKAY;
			s_next.rdata  = 8'h00;
			if (s_axi_araddr == `STT_OFF_CTRL)
				s_next.rdata = s_reg.ctrl;
			else if (s_axi_araddr == `STT_OFF_MODE)
				s_next.rdata = s_reg.mode;
			else if (s_axi_araddr == `STT_OFF_CNT_LO
				|| s_axi_araddr == `STT_OFF_MA_LO)
				s_next.rdata = s_reg.hold_buf;
			else if (s_axi_araddr == `STT_OFF_CNT_HI)
			begin
				s_next.rdata    = {6'h00, s_reg.cnt[9:8]};
				s_next.hold_buf = s_reg.cnt[7:0];
			end
			else if (s_axi_araddr == `STT_OFF_MA_HI)
			begin
				s_next.rdata    = {6'h00, s_reg.match_a[9:8]};
				s_next.hold_buf = s_reg.match_a[7:0];
			end
			else if (s_axi_araddr == `STT_OFF_STATUS)
				s_next.rdata = {6'h00, s_reg.flag_p, s_reg.flag_a};
			else
				s_next.rresp = RESP_SLVERR;
		end
		s_next.arready = !s_next.rvalid;
		s_next.awready = !s_next.aw_got && !s_next.bvalid;
		s_next.wready  = !s_next.w_got && !s_next.bvalid;
		s_next.pin_out = (operating_mode_field == stt_pkg::STT_MODE_TMR)
			? 1'b0 : (s_next.lvl ^ out_invert);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg          <= '0;
			s_reg.ctrl     <= `STT_CTRL_RST;
			s_reg.mode     <= `STT_MODE_RST;
			s_reg.sp       <= stt_pkg::STT_SP_IDLE;
		end
		else
			s_reg <= s_next;
	end

	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready  = s_reg.wready;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rresp   = s_reg.rresp;
	assign s_axi_rdata   = {24'h00_0000, s_reg.rdata};
	assign timer_out_pin = s_reg.pin_out;
	assign match_a_req   = s_reg.req_a;
	assign match_p_req   = s_reg.req_p;

endmodule : stt_timer
